/* File: sscc_pkg.sv */
`default_nettype none
package sscc_pkg;
  // =====================================================
  // Cyclic status byte layout and control byte lock bit
  localparam int unsigned BIT_DIAG = 7;
  localparam int unsigned BIT_STATE = 3;
  localparam int unsigned BIT_STAT2 = 2;
  localparam int unsigned BIT_DOOR = 0;
  localparam int unsigned BIT_LATCH = 3;
  localparam int unsigned BIT_LOCKED = 1;
  localparam int unsigned BIT_LOCK_REQ = 0;
  // =====================================================
  // Acyclic indices
  localparam logic [5:0] IDX_IDENT = 6'h02;
  localparam logic [5:0] IDX_VERSION = 6'h03;
  localparam logic [5:0] IDX_PARTS = 6'h05;
  localparam logic [5:0] IDX_SOL_CYC = 6'h11;
  localparam logic [5:0] IDX_ERR_CUR = 6'h12;
  localparam logic [5:0] IDX_ERR_LAST = 6'h13;
  localparam logic [5:0] IDX_ERR_SIZE = 6'h14;
  localparam logic [5:0] IDX_ERR_NUM = 6'h15;
  localparam logic [5:0] IDX_TAG_DET = 6'h16;
  localparam logic [5:0] IDX_TAG_TAUGHT = 6'h17;
  localparam logic [5:0] IDX_TAG_BLOCK = 6'h18;
  localparam logic [5:0] IDX_VOLTAGE = 6'h19;
  localparam logic [5:0] IDX_TEMP = 6'h1A;
  localparam logic [5:0] IDX_DOOR_CYC = 6'h1B;
  localparam logic [5:0] IDX_SOFT_RST = 6'h1D;
  localparam logic [5:0] IDX_FACT_RST = 6'h1E;
  // =====================================================
  // Answer lengths and misc
  localparam logic [2:0] LEN_NONE = 3'h0;
  localparam logic [2:0] LEN_1 = 3'h1;
  localparam logic [2:0] LEN_2 = 3'h2;
  localparam logic [2:0] LEN_3 = 3'h3;
  localparam logic [2:0] LEN_5 = 3'h5;
  localparam logic [2:0] LEN_6 = 3'h6;
  localparam logic [7:0] ACK_BYTE = 8'h00;
  localparam logic [7:0] ERR_NONE = 8'h00;
  localparam logic [7:0] ERR_CROSS = 8'h01;
  localparam logic [7:0] ERR_INTERNAL = 8'h02;
  localparam logic [4:0] MAX_CHAIN = 5'h14;
  localparam int unsigned LOG_DEPTH = 8;
  localparam logic [3:0] LOG_DEPTH_V = 4'h8;
  // Arbitrary neutral identity values.
  localparam logic [47:0] IDENT_VALUE = 48'h0000_0000_0001;
  localparam logic [39:0] VERSION_VALUE = 40'h00_0000_0001;
  localparam logic [7:0] SER_DIVIDE = 8'h27;
  // =====================================================
  // Carried groups
  typedef struct packed {
    logic door_closed;
    logic latch_engaged;
    logic fault;
    logic [39:0] tag_detected;
    logic [39:0] tag_taught;
    logic [39:0] tag_blocked;
    logic [15:0] voltage;
    logic [7:0] temperature;
  } sscc_sense_t;
  typedef struct packed {
    logic [7:0] byte_one;
    logic [7:0] byte_two;
  } sscc_cyclic_t;
  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_SEND = 3'b010,
    ST_GAP = 3'b100
  } sscc_tx_state_t;
  // =====================================================
  function automatic logic [2:0] sscc_answer_len(input logic [5:0] idx);
    case (idx)
      IDX_IDENT: sscc_answer_len = LEN_6;
      IDX_VERSION: sscc_answer_len = LEN_5;
      IDX_PARTS, IDX_VOLTAGE: sscc_answer_len = LEN_2;
      IDX_SOL_CYC, IDX_DOOR_CYC: sscc_answer_len = LEN_3;
      IDX_TAG_DET, IDX_TAG_TAUGHT, IDX_TAG_BLOCK: sscc_answer_len = LEN_5;
      IDX_ERR_CUR, IDX_ERR_LAST, IDX_ERR_SIZE, IDX_ERR_NUM, IDX_TEMP, IDX_SOFT_RST,
      IDX_FACT_RST: sscc_answer_len = LEN_1;
      default: sscc_answer_len = LEN_NONE;
    endcase
  endfunction : sscc_answer_len
endpackage : sscc_pkg
`default_nettype wire

/* File: sscc_safety.sv */
`default_nettype none
module sscc_safety
  import sscc_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic enable_in_a_i,
  input wire logic enable_in_b_i,
  input wire logic swap_seen_i,
  input wire logic door_closed_i,
  input wire logic fault_i,
  output logic cross_fault_o,
  output logic out_on_o
);
  // =====================================================
  // Cross-wiring latch and output gate
  logic cross_q;
  logic cross_d;
  logic on_q;
  logic on_d;
  always_comb begin
    cross_d = cross_q | swap_seen_i;
    // Only hard-wired inputs decide; nothing from the communication line enters here.
    on_d = enable_in_a_i & enable_in_b_i & door_closed_i & ~fault_i & ~cross_d;
  end
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      cross_q <= 1'b0;
      on_q <= 1'b0;
    end else begin
      cross_q <= cross_d;
      on_q <= on_d;
    end
  end
  assign cross_fault_o = cross_q;
  assign out_on_o = on_q;
endmodule : sscc_safety
`default_nettype wire

/* File: sscc_tx.sv */
`default_nettype none
module sscc_tx
  import sscc_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic tick_i,
  input wire logic start_i,
  input wire logic [47:0] data_i,
  input wire logic [2:0] len_i,
  output logic busy_o,
  output logic [7:0] byte_o,
  output logic byte_valid_o
);
  // =====================================================
  // Sends len bytes, most significant first, one per tick.
  sscc_tx_state_t st_q, st_d;
  logic [47:0] sh_q, sh_d;
  logic [2:0] cnt_q, cnt_d;
  logic [7:0] byte_q, byte_d;
  logic bv_q, bv_d;
  always_comb begin
    st_d = st_q;
    sh_d = sh_q;
    cnt_d = cnt_q;
    byte_d = byte_q;
    bv_d = 1'b0;
    case (st_q)
      ST_IDLE: begin
        if (start_i && len_i != LEN_NONE) begin
          sh_d = data_i << (8 * (6 - len_i));
          cnt_d = len_i;
          st_d = ST_SEND;
        end
      end
      ST_SEND: begin
        if (tick_i) begin
          byte_d = sh_q[47:40];
          bv_d = 1'b1;
          sh_d = {sh_q[39:0], 8'h00};
          cnt_d = cnt_q - 3'h1;
          if (cnt_q == LEN_1) begin
            st_d = ST_GAP;
          end
        end
      end
      ST_GAP: begin
        if (tick_i) begin
          st_d = ST_IDLE;
        end
      end
      default: st_d = ST_IDLE;
    endcase
  end
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      st_q <= ST_IDLE;
      sh_q <= 48'h0;
      cnt_q <= 3'h0;
      byte_q <= 8'h00;
      bv_q <= 1'b0;
    end else begin
      st_q <= st_d;
      sh_q <= sh_d;
      cnt_q <= cnt_d;
      byte_q <= byte_d;
      bv_q <= bv_d;
    end
  end
  assign busy_o = (st_q != ST_IDLE);
  assign byte_o = byte_q;
  assign byte_valid_o = bv_q;
endmodule : sscc_tx
`default_nettype wire

/* File: sscc_top.sv */
`default_nettype none
// How it works
// - An open guard or the sensed fault input drops the safety outputs; stored fault codes only set the diagnostic bit.
// - Enable inputs fed from swapped upstream channels force a latched fault.
// - Status byte one: diagnostic bit 7, state 3, status 2, door 0.
// - Status byte two: latch element bit 3, lock engaged bit 1.
// - Cyclic status bytes are sent continuously without any request.
// - Acyclic answers are sent only in reply to a request.
// - Control byte bit 0 engages guard locking when set, releases when clear.
// - Index 3 answers version, 2 identity, 5 participant count.
// - Error indices 0x12 to 0x15 each answer one byte.
// - Tag indices 0x16 to 0x18 each answer five bytes.
// - Counters, voltage and temperature answer at indices 0x11, 0x1B, 0x19, 0x1A.
// - Indices 0x1D and 0x1E reset soft or factory, answered by one byte.
// - A reset request over the link clears the pending error message.
// - Safety outputs never depend on anything from the communication line.
// - The monitoring output shows door position or guard lock by variant.
// - Both channel inputs form a dual-channel enable from upstream or supply.
module sscc_top
  import sscc_pkg::*;
#(
  parameter bit MON_IS_LOCK = 1'b0
) (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic enable_in_a_i,
  input wire logic enable_in_b_i,
  input wire logic swap_seen_i,
  input wire sscc_sense_t sense_i,
  input wire logic [4:0] chain_count_i,
  input wire logic [7:0] fault_code_i,
  input wire logic fault_code_valid_i,
  input wire logic door_cycle_i,
  input wire logic ctrl_valid_i,
  input wire logic [7:0] ctrl_byte_i,
  input wire logic req_valid_i,
  input wire logic [5:0] req_index_i,
  input wire logic [7:0] req_arg_i,
  output logic safety_out_a_o,
  output logic safety_out_b_o,
  output logic monitor_o,
  output logic lock_solenoid_o,
  output sscc_cyclic_t cyclic_o,
  output logic cyclic_valid_o,
  output logic [7:0] acyc_byte_o,
  output logic acyc_valid_o,
  output logic acyc_busy_o,
  output logic soft_reset_o,
  output logic factory_reset_o
);
  // =====================================================
  // Clock divider for the byte rate
  logic [7:0] div_q, div_d;
  logic tick_q, tick_d;
  always_comb begin
    tick_d = (div_q == SER_DIVIDE);
    div_d = tick_d ? 8'h00 : div_q + 8'h01;
  end
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      div_q <= 8'h00;
      tick_q <= 1'b0;
    end else begin
      div_q <= div_d;
      tick_q <= tick_d;
    end
  end
  // =====================================================
  // Safety path
  logic cross_fault;
  logic out_on;
  logic any_fault;
  sscc_safety u_safety (
    .clk_i(clk_i),
    .rst_n_i(rst_n_i),
    .enable_in_a_i(enable_in_a_i),
    .enable_in_b_i(enable_in_b_i),
    .swap_seen_i(swap_seen_i),
    .door_closed_i(sense_i.door_closed),
    .fault_i(sense_i.fault),
    .cross_fault_o(cross_fault),
    .out_on_o(out_on)
  );
  // =====================================================
  // Lock control, error log and counters
  logic lock_q, lock_d;
  logic [7:0] fault_code_q, fault_code_d;
  logic [7:0] last_code_q, last_code_d;
  logic [7:0] log_q [LOG_DEPTH];
  logic [7:0] log_d [LOG_DEPTH];
  logic [3:0] log_size_q, log_size_d;
  logic [2:0] log_wr_q, log_wr_d;
  logic [23:0] sol_cyc_q, sol_cyc_d;
  logic [23:0] door_cyc_q, door_cyc_d;
  logic cross_seen_q, cross_seen_d;
  logic soft_q, soft_d;
  logic fact_q, fact_d;
  logic [7:0] new_code;
  logic new_err;
  logic [2:0] req_len;
  logic req_ok;
  logic tx_busy;
  assign any_fault = sense_i.fault | (fault_code_q != ERR_NONE);
  assign req_len = sscc_answer_len(req_index_i);
  assign req_ok = req_valid_i && (req_len != LEN_NONE) && !tx_busy;
  always_comb begin
    new_err = 1'b0;
    new_code = fault_code_i;
    if (cross_fault && !cross_seen_q) begin
      new_err = 1'b1;
      new_code = ERR_CROSS;
    end else if (fault_code_valid_i && fault_code_i != ERR_NONE) begin
      new_err = 1'b1;
    end
    lock_d = lock_q;
    if (ctrl_valid_i) begin
      lock_d = ctrl_byte_i[BIT_LOCK_REQ];
    end
    cross_seen_d = cross_seen_q | cross_fault;
    fault_code_d = fault_code_q;
    last_code_d = last_code_q;
    log_d = log_q;
    log_size_d = log_size_q;
    log_wr_d = log_wr_q;
    // The acknowledge clears first so a fault arriving in the same cycle still lands.
    if (req_ok && req_index_i == IDX_SOFT_RST) begin
      fault_code_d = ERR_NONE;
    end
    if (new_err) begin
      fault_code_d = new_code;
      last_code_d = new_code;
      log_d[log_wr_q] = new_code;
      log_wr_d = log_wr_q + 3'h1;
      if (log_size_q != LOG_DEPTH_V) begin
        log_size_d = log_size_q + 4'h1;
      end
    end
    sol_cyc_d = sol_cyc_q + {23'h0, (lock_d != lock_q)};
    door_cyc_d = door_cyc_q + {23'h0, door_cycle_i};
    soft_d = req_ok && (req_index_i == IDX_SOFT_RST);
    fact_d = req_ok && (req_index_i == IDX_FACT_RST);
    if (fact_d) begin
      log_size_d = 4'h0;
      log_wr_d = 3'h0;
      fault_code_d = ERR_NONE;
      last_code_d = ERR_NONE;
    end
  end
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      lock_q <= 1'b0;
      fault_code_q <= ERR_NONE;
      last_code_q <= ERR_NONE;
      log_size_q <= 4'h0;
      log_wr_q <= 3'h0;
      sol_cyc_q <= 24'h0;
      door_cyc_q <= 24'h0;
      cross_seen_q <= 1'b0;
      soft_q <= 1'b0;
      fact_q <= 1'b0;
      for (int i = 0; i < LOG_DEPTH; i++) begin
        log_q[i] <= 8'h00;
      end
    end else begin
      lock_q <= lock_d;
      fault_code_q <= fault_code_d;
      last_code_q <= last_code_d;
      log_size_q <= log_size_d;
      log_wr_q <= log_wr_d;
      sol_cyc_q <= sol_cyc_d;
      door_cyc_q <= door_cyc_d;
      cross_seen_q <= cross_seen_d;
      soft_q <= soft_d;
      fact_q <= fact_d;
      log_q <= log_d;
    end
  end
  // =====================================================
  // Acyclic answer select
  logic [47:0] ans;
  logic [7:0] ans_err_num;
  logic [4:0] parts;
  assign parts = (chain_count_i > MAX_CHAIN) ? MAX_CHAIN : chain_count_i;
  assign ans_err_num = (req_arg_i < {4'h0, log_size_q}) ? log_q[req_arg_i[2:0]] : ERR_NONE;
  always_comb begin
    case (req_index_i)
      IDX_IDENT: ans = IDENT_VALUE;
      IDX_VERSION: ans = {8'h00, VERSION_VALUE};
      IDX_PARTS: ans = {43'h0, parts};
      IDX_ERR_CUR: ans = {40'h0, fault_code_q};
      IDX_ERR_LAST: ans = {40'h0, last_code_q};
      IDX_ERR_SIZE: ans = {44'h0, log_size_q};
      IDX_ERR_NUM: ans = {40'h0, ans_err_num};
      IDX_TAG_DET: ans = {8'h00, sense_i.tag_detected};
      IDX_TAG_TAUGHT: ans = {8'h00, sense_i.tag_taught};
      IDX_TAG_BLOCK: ans = {8'h00, sense_i.tag_blocked};
      IDX_SOL_CYC: ans = {24'h0, sol_cyc_q};
      IDX_DOOR_CYC: ans = {24'h0, door_cyc_q};
      IDX_VOLTAGE: ans = {32'h0, sense_i.voltage};
      IDX_TEMP: ans = {40'h0, sense_i.temperature};
      default: ans = {40'h0, ACK_BYTE};
    endcase
  end
  logic [7:0] tx_byte;
  logic tx_valid;
  sscc_tx u_tx (
    .clk_i(clk_i),
    .rst_n_i(rst_n_i),
    .tick_i(tick_q),
    .start_i(req_ok),
    .data_i(ans),
    .len_i(req_len),
    .busy_o(tx_busy),
    .byte_o(tx_byte),
    .byte_valid_o(tx_valid)
  );
  // =====================================================
  // Cyclic status and output registers
  sscc_cyclic_t cyc_q, cyc_d;
  logic cv_q, cv_d;
  logic mon_q, mon_d;
  logic busy_q;
  always_comb begin
    cyc_d = '0;
    cyc_d.byte_one[BIT_DIAG] = any_fault | cross_fault;
    cyc_d.byte_one[BIT_STATE] = out_on;
    cyc_d.byte_one[BIT_STAT2] = lock_q;
    cyc_d.byte_one[BIT_DOOR] = sense_i.door_closed;
    cyc_d.byte_two[BIT_LATCH] = sense_i.latch_engaged;
    cyc_d.byte_two[BIT_LOCKED] = lock_q & sense_i.latch_engaged;
    cv_d = tick_q;
    mon_d = MON_IS_LOCK ? (lock_q & sense_i.latch_engaged) : sense_i.door_closed;
  end
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      cyc_q <= '0;
      cv_q <= 1'b0;
      mon_q <= 1'b0;
      busy_q <= 1'b0;
    end else begin
      cyc_q <= cyc_d;
      cv_q <= cv_d;
      mon_q <= mon_d;
      busy_q <= tx_busy | req_ok;
    end
  end
  assign safety_out_a_o = out_on;
  assign safety_out_b_o = out_on;
  assign monitor_o = mon_q;
  assign lock_solenoid_o = lock_q;
  assign cyclic_o = cyc_q;
  assign cyclic_valid_o = cv_q;
  assign acyc_byte_o = tx_byte;
  assign acyc_valid_o = tx_valid;
  assign acyc_busy_o = busy_q;
  assign soft_reset_o = soft_q;
  assign factory_reset_o = fact_q;
endmodule : sscc_top
`default_nettype wire

/* File: sscc_chk.sv */
`default_nettype none
module sscc_chk
  import sscc_pkg::*;
#(
  parameter bit MON_IS_LOCK = 1'b0
) (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic enable_in_a_i,
  input wire logic enable_in_b_i,
  input wire logic swap_seen_i,
  input wire sscc_sense_t sense_i,
  input wire logic ctrl_valid_i,
  input wire logic [7:0] ctrl_byte_i,
  input wire logic req_valid_i,
  input wire logic [5:0] req_index_i,
  input wire logic safety_out_a_o,
  input wire logic safety_out_b_o,
  input wire logic monitor_o,
  input wire logic lock_solenoid_o,
  input wire sscc_cyclic_t cyclic_o,
  input wire logic cyclic_valid_o,
  input wire logic acyc_valid_o,
  input wire logic acyc_busy_o,
  input wire logic soft_reset_o
);
  // ====
  // Checks
  // Indices that carry an answer.
  localparam logic [63:0] DEF_MASK = 64'h0000_0000_6FFE_002C;
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (!rst_n_i);
  a_guard_open_off: assert property ((!sense_i.door_closed || sense_i.fault) |=> !safety_out_a_o && !safety_out_b_o)
    else $error("safety on with guard open or fault");
  a_on_needs_all: assert property ((safety_out_a_o || safety_out_b_o) |->
    $past(enable_in_a_i && enable_in_b_i && sense_i.door_closed && !sense_i.fault))
    else $error("safety on without full enable");
  a_cross_latch: assert property (swap_seen_i |=> (!safety_out_a_o && !safety_out_b_o)[*8])
    else $error("cross wiring did not hold outputs off");
  a_status_bits: assert property ($past(rst_n_i) |-> cyclic_o.byte_one[BIT_DOOR] == $past(sense_i.door_closed)
    && cyclic_o.byte_two[BIT_LATCH] == $past(sense_i.latch_engaged)
    && (cyclic_o.byte_one & 8'h72) == 8'h00 && (cyclic_o.byte_two & 8'hF5) == 8'h00)
    else $error("cyclic status bits wrong");
  a_cyclic_period: assert property (cyclic_valid_o |-> ##40 cyclic_valid_o)
    else $error("cyclic period wrong");
  a_answer_asked: assert property ($rose(acyc_busy_o) |-> $past(req_valid_i))
    else $error("answer without request");
  a_answer_soon: assert property ($rose(acyc_busy_o) |-> ##[1:41] acyc_valid_o)
    else $error("answer byte late");
  a_lock_follow: assert property (ctrl_valid_i |=> lock_solenoid_o == $past(ctrl_byte_i[BIT_LOCK_REQ]))
    else $error("lock output wrong");
  a_undef_ignored: assert property (req_valid_i && !acyc_busy_o && !DEF_MASK[req_index_i] |=> !acyc_busy_o)
    else $error("undefined index answered");
  a_monitor_door: assert property (!MON_IS_LOCK && $past(rst_n_i) |-> monitor_o == $past(sense_i.door_closed))
    else $error("monitor output wrong");
  a_soft_pulse: assert property (soft_reset_o |=> !soft_reset_o)
    else $error("soft reset pulse too long");
endmodule : sscc_chk
bind sscc_top sscc_chk #(.MON_IS_LOCK(MON_IS_LOCK)) i_chk (.clk_i, .rst_n_i, .enable_in_a_i, .enable_in_b_i,
  .swap_seen_i, .sense_i, .ctrl_valid_i, .ctrl_byte_i, .req_valid_i, .req_index_i, .safety_out_a_o,
  .safety_out_b_o, .monitor_o, .lock_solenoid_o, .cyclic_o, .cyclic_valid_o, .acyc_valid_o, .acyc_busy_o,
  .soft_reset_o);
`default_nettype wire

/* File: sscc_gw_model.sv */
`default_nettype none
module sscc_gw_model
  import sscc_pkg::*;
(
  input wire logic clk_i,
  input wire logic [7:0] acyc_byte_i,
  input wire logic acyc_valid_i,
  input wire logic acyc_busy_i,
  output logic req_valid_o,
  output logic [5:0] req_index_o,
  output logic [7:0] req_arg_o,
  output logic ctrl_valid_o,
  output logic [7:0] ctrl_byte_o
);
  timeunit 1ns;
  timeprecision 1ps;
  // ====
  // Gateway side
  logic [7:0] got[$];
  initial begin
    req_valid_o = 1'b0;
    req_index_o = 6'h00;
    req_arg_o = 8'h00;
    ctrl_valid_o = 1'b0;
    ctrl_byte_o = 8'h00;
  end
  always @(posedge clk_i) begin
    if (acyc_valid_i) begin
      got.push_back(acyc_byte_i);
    end
  end
  // Released lines show the inverse, so a stale index never passes for a live one.
  task automatic pulse(input logic [5:0] idx);
    @(negedge clk_i);
    req_valid_o = 1'b1;
    req_index_o = idx;
    req_arg_o = 8'h00;
    @(negedge clk_i);
    req_valid_o = 1'b0;
    req_index_o = ~idx;
    req_arg_o = 8'hFF;
  endtask : pulse
  task automatic ask(input logic [5:0] idx, input logic [5:0] extra, output bit late);
    got.delete();
    pulse(idx);
    if (extra != 6'h00) begin
      repeat (5) @(negedge clk_i);
      pulse(extra);
    end
    late = 1'b1;
    for (int i = 0; i < 400; i++) begin
      @(negedge clk_i);
      if (!acyc_busy_i && i > 2) begin
        late = 1'b0;
        break;
      end
    end
    repeat (41) @(negedge clk_i);
  endtask : ask
  task automatic ctrl(input logic [7:0] b);
    @(negedge clk_i);
    ctrl_valid_o = 1'b1;
    ctrl_byte_o = b;
    @(negedge clk_i);
    ctrl_valid_o = 1'b0;
    ctrl_byte_o = ~b;
  endtask : ctrl
endmodule : sscc_gw_model
`default_nettype wire

/* File: tb_top.sv */
`default_nettype none
module tb_top
  import sscc_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  `define CHK(nm, ex, sn) \
  begin \
    check_count++; \
    if ((sn) !== (ex)) begin \
      fail_count++; \
      $display("wrong value %s expected %0h seen %0h", nm, ex, sn); \
    end \
  end
  typedef struct packed {
    logic [5:0] idx;
    logic [3:0] len;
    logic [47:0] val;
  } sscc_row_t;
  logic clk_i, rst_n_i, enable_in_a_i, enable_in_b_i, swap_seen_i, fault_code_valid_i, door_cycle_i;
  logic req_valid_i, ctrl_valid_i, safety_out_a_o, safety_out_b_o, monitor_o, lock_solenoid_o;
  logic cyclic_valid_o, acyc_valid_o, acyc_busy_o, soft_reset_o, factory_reset_o;
  logic [4:0] chain_count_i;
  logic [5:0] req_index_i;
  logic [7:0] fault_code_i, ctrl_byte_i, req_arg_i, acyc_byte_o;
  logic [47:0] ans;
  sscc_sense_t sense_i;
  sscc_cyclic_t cyclic_o;
  sscc_row_t rows[20];
  logic [3:0] sc[5] = '{4'h6, 4'hA, 4'hC, 4'hF, 4'hE};
  int fail_count = 0;
  int check_count = 0;
  int soft_seen = 0;
  int fact_seen = 0;
  int ans_len, n;
  always #12.5 clk_i = ~clk_i;
  sscc_top #(.MON_IS_LOCK(1'b0)) i_dut (.clk_i, .rst_n_i, .enable_in_a_i, .enable_in_b_i, .swap_seen_i, .sense_i,
    .chain_count_i, .fault_code_i, .fault_code_valid_i, .door_cycle_i, .ctrl_valid_i, .ctrl_byte_i, .req_valid_i,
    .req_index_i, .req_arg_i, .safety_out_a_o, .safety_out_b_o, .monitor_o, .lock_solenoid_o, .cyclic_o,
    .cyclic_valid_o, .acyc_byte_o, .acyc_valid_o, .acyc_busy_o, .soft_reset_o, .factory_reset_o);
  sscc_gw_model i_gw (.clk_i, .acyc_byte_i(acyc_byte_o), .acyc_valid_i(acyc_valid_o), .acyc_busy_i(acyc_busy_o),
    .req_valid_o(req_valid_i), .req_index_o(req_index_i), .req_arg_o(req_arg_i), .ctrl_valid_o(ctrl_valid_i),
    .ctrl_byte_o(ctrl_byte_i));
  always @(posedge clk_i) begin
    if (soft_reset_o === 1'b1) soft_seen++;
    if (factory_reset_o === 1'b1) fact_seen++;
  end
  // ====
  // Tasks
  task automatic complete_run();
    $display("checks %0d mismatches %0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : complete_run
  task automatic do_reset();
    @(negedge clk_i);
    rst_n_i = 1'b0;
    repeat (20) @(negedge clk_i);
    `CHK("reset outputs", 5'h00, {safety_out_a_o, safety_out_b_o, lock_solenoid_o, acyc_busy_o, cyclic_valid_o})
    rst_n_i = 1'b1;
  endtask : do_reset
  task automatic query(input logic [5:0] idx, input logic [5:0] extra);
    bit late;
    i_gw.ask(idx, extra, late);
    if (late) begin
      fail_count++;
      complete_run();
    end
    ans = '0;
    ans_len = i_gw.got.size();
    for (int k = 0; k < ans_len; k++) begin
      ans = {ans[39:0], i_gw.got[k]};
    end
  endtask : query
  // ====
  // Sequence
  initial begin
    clk_i = 1'b0;
    rst_n_i = 1'b0;
    {enable_in_a_i, enable_in_b_i, swap_seen_i, fault_code_valid_i, door_cycle_i} = 5'h18;
    chain_count_i = 5'h14;
    fault_code_i = 8'h00;
    sense_i = '{1'b1, 1'b1, 1'b0, 40'h11_2233_4455, 40'hAA_BBCC_DDEE, 40'h01_0203_0405, 16'h5DC0, 8'h2A};
    rows = '{'{IDX_IDENT, 4'h6, IDENT_VALUE}, '{IDX_VERSION, 4'h5, 48'(VERSION_VALUE)}, '{IDX_PARTS, 4'h2, 48'h14},
      '{IDX_SOL_CYC, 4'h3, 48'h3}, '{IDX_DOOR_CYC, 4'h3, 48'h2}, '{IDX_VOLTAGE, 4'h2, 48'h5DC0},
      '{IDX_TEMP, 4'h1, 48'h2A}, '{IDX_TAG_DET, 4'h5, 48'h11_2233_4455}, '{IDX_TAG_TAUGHT, 4'h5, 48'hAA_BBCC_DDEE},
      '{IDX_TAG_BLOCK, 4'h5, 48'h01_0203_0405}, '{IDX_ERR_CUR, 4'h1, 48'h5}, '{IDX_ERR_LAST, 4'h1, 48'h5},
      '{IDX_ERR_SIZE, 4'h1, 48'h1}, '{IDX_ERR_NUM, 4'h1, 48'h5}, '{IDX_SOFT_RST, 4'h1, 48'(ACK_BYTE)},
      '{IDX_ERR_CUR, 4'h1, 48'(ERR_NONE)}, '{IDX_FACT_RST, 4'h1, 48'(ACK_BYTE)}, '{IDX_ERR_SIZE, 4'h1, 48'h0},
      '{6'h04, 4'h0, 48'h0}, '{6'h3F, 4'h0, 48'h0}};
    do_reset();
    repeat (2) @(negedge clk_i);
    `CHK("safety on", 2'b11, {safety_out_a_o, safety_out_b_o})
    for (int i = 0; i < 3; i++) begin
      i_gw.ctrl(i == 1 ? 8'hFE : 8'h01);
      `CHK("lock", 1'(i != 1), lock_solenoid_o)
    end
    for (int k = 0; k < 2; k++) begin
      @(negedge clk_i);
      door_cycle_i = 1'b1;
      @(negedge clk_i);
      door_cycle_i = 1'b0;
    end
    fault_code_i = 8'h05;
    fault_code_valid_i = 1'b1;
    @(negedge clk_i);
    fault_code_valid_i = 1'b0;
    fault_code_i = 8'hFA;
    repeat (2) @(negedge clk_i);
    `CHK("status bits", 2'b11, {cyclic_o.byte_one[BIT_STAT2], cyclic_o.byte_two[BIT_LATCH]})
    `CHK("diag state lock", 3'b111, {cyclic_o.byte_one[BIT_DIAG], cyclic_o.byte_one[BIT_STATE], cyclic_o.byte_two[BIT_LOCKED]})
    for (int r = 0; r < 20; r++) begin
      query(rows[r].idx, 6'h00);
      `CHK("answer", {rows[r].len, rows[r].val}, {4'(ans_len), ans})
    end
    `CHK("reset pulses", 2'b11, {soft_seen == 1, fact_seen == 1})
    query(IDX_TEMP, IDX_PARTS);
    `CHK("busy refusal", {4'h1, 48'h2A}, {4'(ans_len), ans})
    n = 0;
    for (int i = 0; i < 400; i++) begin
      @(negedge clk_i);
      if (cyclic_valid_o === 1'b1) n++;
    end
    `CHK("cyclic pulses", 10, n)
    for (int s = 0; s < 5; s++) begin
      {enable_in_a_i, enable_in_b_i, sense_i.door_closed, sense_i.fault} = sc[s];
      repeat (2) @(negedge clk_i);
      `CHK("safety pair", {2{sc[s] == 4'hE}}, {safety_out_a_o, safety_out_b_o})
      `CHK("door view", {2{sc[s][1]}}, {monitor_o, cyclic_o.byte_one[BIT_DOOR]})
    end
    swap_seen_i = 1'b1;
    repeat (2) @(negedge clk_i);
    swap_seen_i = 1'b0;
    repeat (10) @(negedge clk_i);
    `CHK("cross fault", 2'b00, {safety_out_a_o, safety_out_b_o})
    query(IDX_ERR_CUR, 6'h00);
    `CHK("cross code", ERR_CROSS, ans[7:0])
    do_reset();
    repeat (2) @(negedge clk_i);
    `CHK("on after reset", 2'b11, {safety_out_a_o, safety_out_b_o})
    complete_run();
  end
endmodule : tb_top
`default_nettype wire
